// ---- rtl/unr_pkg.sv ----
package unr_pkg;
  localparam int BANK_COUNT = 8;
  localparam int BANK_BITS = 128;
  localparam int BYTE_BITS = 8;
  localparam int BYTES_PER_BANK = BANK_BITS / BYTE_BITS;
  localparam int BANK_IDX_W = 3;
  localparam int BYTE_IDX_W = 4;
  localparam int ADDR_W = BANK_IDX_W + BYTE_IDX_W;
  localparam int ADDR_BANK_LSB = BYTE_IDX_W;
  localparam logic [7:0] RESET_DATA = 8'h00;
  localparam logic [127:0] ERASED_BANK = {128{1'b1}};

  // Programming path states, Gray coded along erase then write
  typedef enum logic [1:0] {
    UNR_IDLE = 2'h0,
    UNR_ERASE = 2'h1,
    UNR_LOAD = 2'h3,
    UNR_DONE = 2'h2
  } unr_prog_state_type;
endpackage

// ---- rtl/unr_nvm_read_port.sv ----
// Behaviour
// - Store is eight banks of 128 bits; programming writes whole banks.
// - Core reads return one byte per access on the system clock.
// - Upper three address bits select bank, lower four select byte.
// - Erase and write only via the programming path; core cannot write.
// - Contents readable through programming path or core address port.
// - Program by erase then write, optionally through AES decryption.
`timescale 1ns/1ns
module unr_nvm_read_port #(
  parameter bit AES_PRESENT = 1'b1
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // Core read port
  input wire logic rd_en_i,
  input wire logic [6:0] rd_addr_i,
  output logic [7:0] rd_data_o,
  output logic rd_valid_o,
  // Programming path side (bank granular)
  input wire logic prog_start_i,
  input wire logic [2:0] prog_bank_i,
  input wire logic [127:0] prog_data_i,
  input wire logic prog_encrypted_i,
  input wire logic [127:0] aes_plain_i,
  input wire logic aes_plain_valid_i,
  output logic aes_req_o,
  output logic [127:0] aes_cipher_o,
  output logic prog_busy_o,
  output logic prog_done_o,
  output logic prog_error_o,
  input wire logic rb_req_i,
  input wire logic [2:0] rb_bank_i,
  output logic [127:0] rb_data_o
);

  typedef struct packed {
    logic [unr_pkg::BANK_COUNT-1:0][unr_pkg::BANK_BITS-1:0] mem;
    unr_pkg::unr_prog_state_type st;
    logic [2:0] bank;
    logic [127:0] buf_data;
    logic enc;
    logic [7:0] rd_data;
    logic rd_valid;
    logic aes_req;
    logic busy;
    logic done;
    logic err;
    logic [127:0] rb_data;
  } unr_state_type;

  unr_state_type state_reg;
  unr_state_type state_next;

  function automatic logic [7:0] pick_byte(input logic [127:0] bank_word,
                                          input logic [3:0] idx);
    pick_byte = bank_word[idx*unr_pkg::BYTE_BITS +: unr_pkg::BYTE_BITS];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    state_next = state_reg;
    state_next.done = 1'b0;
    state_next.err = 1'b0;
    state_next.rd_valid = 1'b0;
    if (rd_en_i) begin
      // Bank from high bits, byte from low bits
      state_next.rd_data = pick_byte(
        state_reg.mem[rd_addr_i[unr_pkg::ADDR_W-1:unr_pkg::ADDR_BANK_LSB]],
        rd_addr_i[unr_pkg::BYTE_IDX_W-1:0]);
      state_next.rd_valid = 1'b1;
    end
    if (rb_req_i) begin
      state_next.rb_data = state_reg.mem[rb_bank_i];
    end
    // Only the programming path modifies the array
    case (state_reg.st)
      unr_pkg::UNR_IDLE: begin
        if (prog_start_i) begin
          if (prog_encrypted_i && !AES_PRESENT) begin
            state_next.err = 1'b1;
          end else begin
            state_next.bank = prog_bank_i;
            state_next.buf_data = prog_data_i;
            state_next.enc = prog_encrypted_i;
            state_next.busy = 1'b1;
            state_next.st = unr_pkg::UNR_ERASE;
          end
        end
      end
      unr_pkg::UNR_ERASE: begin
        state_next.mem[state_reg.bank] = unr_pkg::ERASED_BANK;
        state_next.st = unr_pkg::UNR_LOAD;
        state_next.aes_req = state_reg.enc;
      end
      unr_pkg::UNR_LOAD: begin
        if (!state_reg.enc) begin
          state_next.mem[state_reg.bank] = state_reg.buf_data;
          state_next.st = unr_pkg::UNR_DONE;
        end else if (aes_plain_valid_i) begin
          state_next.mem[state_reg.bank] = aes_plain_i;
          state_next.aes_req = 1'b0;
          state_next.st = unr_pkg::UNR_DONE;
        end
      end
      unr_pkg::UNR_DONE: begin
        state_next.busy = 1'b0;
        state_next.done = 1'b1;
        state_next.st = unr_pkg::UNR_IDLE;
      end
      default: begin
        state_next.st = unr_pkg::UNR_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      // Array is nonvolatile: contents survive reset
      state_reg <= '{
        mem: state_reg.mem,
        st: unr_pkg::UNR_IDLE,
        bank: '0,
        buf_data: '0,
        enc: 1'b0,
        rd_data: unr_pkg::RESET_DATA,
        rd_valid: 1'b0,
        aes_req: 1'b0,
        busy: 1'b0,
        done: 1'b0,
        err: 1'b0,
        rb_data: '0
      };
    end else begin
      state_reg <= state_next;
    end
  end

  assign rd_data_o = state_reg.rd_data;
  assign rd_valid_o = state_reg.rd_valid;
  assign aes_req_o = state_reg.aes_req;
  assign aes_cipher_o = state_reg.buf_data;
  assign prog_busy_o = state_reg.busy;
  assign prog_done_o = state_reg.done;
  assign prog_error_o = state_reg.err;
  assign rb_data_o = state_reg.rb_data;

endmodule

// ---- tb/unr_checker.sv ----
`timescale 1ns/1ns
module unr_checker(input wire logic clk_sys_i, rst_n_i, rd_en_i, rd_valid_o, prog_start_i,
  prog_busy_o, prog_done_o, rb_req_i, input wire logic [7:0] rd_data_o,
  input wire logic [127:0] rb_data_o);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  chk_rd_answer: assert property (rd_en_i |=> rd_valid_o) else $error("no valid");
  chk_rd_quiet: assert property (!rd_en_i |=> !rd_valid_o) else $error("stray");
  chk_rd_hold: assert property (!rd_en_i |=> $stable(rd_data_o)) else $error("moved");
  chk_rb_hold: assert property (!rb_req_i |=> $stable(rb_data_o)) else $error("rb");
  chk_prog_busy: assert property (prog_start_i && !prog_busy_o && !prog_done_o |=>
    prog_busy_o) else $error("busy");
  chk_prog_end: assert property (prog_start_i && !prog_busy_o && !prog_done_o |->
    ##[1:20] prog_done_o) else $error("hang");
  chk_done_idle: assert property (prog_done_o |-> !prog_busy_o ##1 !prog_done_o)
    else $error("done");
  chk_busy_span: assert property ($rose(prog_busy_o) |-> prog_busy_o [*3])
    else $error("short");
  cover property (rd_en_i ##1 rd_en_i);
  cover property (prog_done_o);
  cover property (rb_req_i);
endmodule
bind unr_nvm_read_port unr_checker chk(.*);

// ---- tb/unr_aes_model.sv ----
`timescale 1ns/1ns
module unr_aes_model(input wire logic clk_sys_i, aes_req_o,
  input wire logic [127:0] aes_cipher_o,
  output logic aes_plain_valid_i, output logic [127:0] aes_plain_i);
  logic [1:0] wait_reg = 2'h0;
  always_ff @(posedge clk_sys_i) begin
    wait_reg <= aes_req_o ? wait_reg + 2'h1 : 2'h0;
    aes_plain_valid_i <= wait_reg == 2'h2;
    aes_plain_i <= ~aes_cipher_o;
  end
endmodule

// ---- tb/user_nvm_byte_read_port_bench.sv ----
`timescale 1ns/1ns
module user_nvm_byte_read_port_bench;
  logic clk_sys_i = 0, rst_n_i = 0, rd_en_i = 0, prog_start_i = 0, prog_encrypted_i = 0;
  logic rb_req_i = 0, rd_valid_o, aes_plain_valid_i, aes_req_o, prog_busy_o, prog_done_o;
  logic prog_error_o;
  logic [6:0] rd_addr_i = 0;
  logic [2:0] prog_bank_i = 0, rb_bank_i = 0;
  logic [7:0] rd_data_o, q[$];
  logic [127:0] prog_data_i = 0, aes_plain_i, aes_cipher_o, rb_data_o, mem[8];
  int n_errors = 0, total_checks = 0, i;
  always #5 clk_sys_i = ~clk_sys_i;
  unr_nvm_read_port dut(.*);
  unr_aes_model aes(.*);
  task chk(input logic [127:0] e, s, input string n);
    total_checks++;
    if (e !== s) n_errors++;
    if (e !== s) $display("unexpected %s %h %h", n, e, s);
  endtask
  task give_verdict;
    $display("%0d checks %0d errors", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  always @(negedge clk_sys_i) if (rd_valid_o === 1'h1) chk(q.pop_front(), rd_data_o, "rd");
  initial begin
    #20000;
    n_errors++;
    give_verdict;
  end
  initial begin
    void'($urandom(26618));
    repeat (8) @(negedge clk_sys_i);
    rst_n_i = 1;
    for (int b = 0; b < 8; b++) begin
      mem[b] = {$urandom, $urandom, $urandom, $urandom};
      prog_bank_i = 3'(b);
      prog_encrypted_i = b[0];
      prog_data_i = b[0] ? ~mem[b] : mem[b];
      prog_start_i = 1;
      @(negedge clk_sys_i) prog_start_i = 0;
      for (i = 0; i < 20 && prog_done_o !== 1'h1; i++) @(negedge clk_sys_i);
      chk(1, prog_done_o, "done");
      chk(0, prog_error_o, "err");
      chk(0, prog_busy_o, "busy");
      rb_req_i = 1;
      rb_bank_i = 3'(b);
      @(negedge clk_sys_i) rb_req_i = 0;
      chk(mem[b], rb_data_o, "rb");
    end
    $display("prog test end");
    for (int k = 0; k < 300; k++) begin
      rd_en_i = 1'($urandom);
      rd_addr_i = 7'(k * 37);
      if (rd_en_i) q.push_back(mem[rd_addr_i[6:4]][rd_addr_i[3:0] * 8 +: 8]);
      @(negedge clk_sys_i);
    end
    rd_en_i = 0;
    repeat (2) @(negedge clk_sys_i);
    chk(0, q.size(), "left");
    $display("read test end");
    give_verdict;
  end
endmodule
